//--- design/acr_regs.sv
// How it works
// - power-down bit 3 sleeps the chip
// - bit 2 selects reduced-power mode
// - bit 0 sleeps only input amplifier
// - status top two bits fixed part code
// - status bits 13:11 show die number
// - status bit 9 shows low power
// - status bit 8 flags over threshold
// - download checksum match sets bit 7
// - filter pass checksum match sets bit 6
// - bit 5 shows custom coefficients
// - bit 4 mirrors third-stage bypass
// - bits 2:0 mirror rate divider
// - offset is signed, tiny full-scale span
// - gain applied before offset
// - gain code 0x8000 is unity
// - gain resets to 0xA000
// - threshold compared after first decimator
// - threshold resets to 0xCCCC
// - over 4 full-scale samples flags overrange
// - status select redirects next read
// - other selects redirect next read too
// - bits 15:9 of control one self-clear
module acr_regs
  import acr_pkg::*;
#(
  parameter logic [1:0] PART_ID = PART_ID_DEF
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          host_wr_stb,
  input  wire logic [AW-1:0] host_wr_addr,
  input  wire logic [DW-1:0] host_wr_data,
  input  wire logic          host_rd_stb,
  output logic               rd_valid,
  output logic [SW-1:0]      rd_data,
  input  wire logic [2:0]    die_pins,
  input  wire logic          conv_valid,
  input  wire logic [SW-1:0] conv_data,
  input  wire logic          dec1_valid,
  input  wire logic [SW-1:0] dec1_data,
  input  wire logic          mod_valid,
  input  wire logic          mod_full_scale,
  input  wire logic          chk_valid,
  input  wire logic [DW-1:0] chk_data,
  input  wire logic          chk_last,
  output logic               chip_sleep,
  output logic               reduced_power_select,
  output logic               amp_sleep,
  output logic               sync_pulse,
  output logic               coeff_load_enable,
  output logic               coeff_wr_stb,
  output logic [IW-1:0]      coeff_wr_index,
  output logic [DW-1:0]      coeff_wr_data,
  output logic               custom_coeffs_active,
  output logic               third_stage_bypass,
  output logic [2:0]         rate_divider_setting,
  output logic [3:0]         coeff_count,
  output logic               result_valid,
  output logic [SW-1:0]      result_data,
  output logic               overrange
);

  // register group
  logic [DW-1:0] ctrl1_ff;
  logic [DW-1:0] nxt_ctrl1;
  logic [DW-1:0] power_ff;
  logic [DW-1:0] nxt_power;
  logic [DW-1:0] offset_ff;
  logic [DW-1:0] nxt_offset;
  logic [DW-1:0] gain_ff;
  logic [DW-1:0] nxt_gain;
  logic [DW-1:0] thresh_ff;
  logic [DW-1:0] nxt_thresh;
  logic          sync_ff;
  logic          nxt_sync;
  logic [2:0]    die_meta_ff;
  logic [2:0]    die_ff;

  // download group
  logic          load_ff;
  logic          nxt_load;
  logic [IW-1:0] idx_ff;
  logic [IW-1:0] nxt_idx;
  logic [IW-1:0] need_ff;
  logic [IW-1:0] nxt_need;
  logic [DW-1:0] sum_ff;
  logic [DW-1:0] nxt_sum;
  logic [DW-1:0] ref_sum_ff;
  logic [DW-1:0] nxt_ref_sum;
  logic          load_checksum_match_ff;
  logic          nxt_load_checksum_match;
  logic          cust_ff;
  logic          nxt_cust;
  logic          cw_stb_ff;
  logic          nxt_cw_stb;
  logic [IW-1:0] cw_idx_ff;
  logic [IW-1:0] nxt_cw_idx;
  logic [DW-1:0] cw_data_ff;
  logic [DW-1:0] nxt_cw_data;

  // filter pass check group
  logic [DW-1:0] pass_sum_ff;
  logic [DW-1:0] nxt_pass_sum;
  logic          filt_ok_ff;
  logic          nxt_filt_ok;

  // read group
  acr_rdsel_e    sel_ff;
  acr_rdsel_e    nxt_sel;
  logic          rv_ff;
  logic          nxt_rv;
  logic [SW-1:0] rd_ff;
  logic [SW-1:0] nxt_rd;

  logic          reg_wr;
  logic          c1_wr;
  logic [DW-1:0] status_word;
  logic [SW-1:0] corr_data;

  // during a download every write is coefficient data or the checksum word, not a register write
  assign reg_wr = host_wr_stb && !load_ff;
  assign c1_wr  = reg_wr && (host_wr_addr == ADDR_CTRL1);

  always_comb begin
    nxt_ctrl1  = ctrl1_ff & ~C1_SELF_CLR;
    nxt_power  = power_ff;
    nxt_offset = offset_ff;
    nxt_gain   = gain_ff;
    nxt_thresh = thresh_ff;
    nxt_sync   = 1'b0;
    if (reg_wr) begin
      case (host_wr_addr)
        ADDR_CTRL1: begin
          nxt_ctrl1 = host_wr_data & ~C1_SELF_CLR;
          nxt_sync  = host_wr_data[C1_SYNC];
        end
        ADDR_POWER:  nxt_power  = host_wr_data;
        ADDR_OFFSET: nxt_offset = host_wr_data;
        ADDR_GAIN:   nxt_gain   = host_wr_data;
        ADDR_THRESH: nxt_thresh = host_wr_data;
        default:     nxt_sync   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl1_ff    <= CTRL1_RST;
      power_ff    <= POWER_RST;
      offset_ff   <= OFFSET_RST;
      gain_ff     <= GAIN_RST;
      thresh_ff   <= THRESH_RST;
      sync_ff     <= 1'b0;
      die_meta_ff <= 3'h0;
      die_ff      <= 3'h0;
    end else begin
      ctrl1_ff    <= nxt_ctrl1;
      power_ff    <= nxt_power;
      offset_ff   <= nxt_offset;
      gain_ff     <= nxt_gain;
      thresh_ff   <= nxt_thresh;
      sync_ff     <= nxt_sync;
      die_meta_ff <= die_pins;
      die_ff      <= die_meta_ff;
    end
  end

  // coefficient download: (len+1)*3 words, then the checksum word
  always_comb begin
    nxt_load    = load_ff;
    nxt_idx     = idx_ff;
    nxt_need    = need_ff;
    nxt_sum     = sum_ff;
    nxt_ref_sum = ref_sum_ff;
    nxt_load_checksum_match   = load_checksum_match_ff;
    nxt_cust    = cust_ff;
    nxt_cw_stb  = 1'b0;
    nxt_cw_idx  = cw_idx_ff;
    nxt_cw_data = cw_data_ff;
    if (c1_wr && host_wr_data[C1_LOAD]) begin
      nxt_load  = 1'b1;
      nxt_idx   = '0;
      nxt_sum   = '0;
      nxt_load_checksum_match = 1'b0;
      nxt_cust  = 1'b0;
      nxt_need  = IW'((IW'(host_wr_data[C1_LEN_LO +: 4]) + IW'(1)) * COEFF_GROUP);
    end else if (load_ff && host_wr_stb) begin
      if (idx_ff != need_ff) begin
        nxt_idx     = idx_ff + IW'(1);
        nxt_sum     = acr_sum_step(sum_ff, host_wr_data);
        nxt_cw_stb  = 1'b1;
        nxt_cw_idx  = idx_ff;
        nxt_cw_data = host_wr_data;
      end else begin
        nxt_load    = 1'b0;
        nxt_ref_sum = host_wr_data;
        nxt_load_checksum_match   = (sum_ff == host_wr_data);
        nxt_cust    = (sum_ff == host_wr_data);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      load_ff    <= 1'b0;
      idx_ff     <= '0;
      need_ff    <= '0;
      sum_ff     <= '0;
      ref_sum_ff <= '0;
      load_checksum_match_ff   <= 1'b0;
      cust_ff    <= 1'b0;
      cw_stb_ff  <= 1'b0;
      cw_idx_ff  <= '0;
      cw_data_ff <= '0;
    end else begin
      load_ff    <= nxt_load;
      idx_ff     <= nxt_idx;
      need_ff    <= nxt_need;
      sum_ff     <= nxt_sum;
      ref_sum_ff <= nxt_ref_sum;
      load_checksum_match_ff   <= nxt_load_checksum_match;
      cust_ff    <= nxt_cust;
      cw_stb_ff  <= nxt_cw_stb;
      cw_idx_ff  <= nxt_cw_idx;
      cw_data_ff <= nxt_cw_data;
    end
  end

  // regenerated checksum as coefficients stream through the filter
  always_comb begin
    nxt_pass_sum = pass_sum_ff;
    nxt_filt_ok  = filt_ok_ff;
    if (!cust_ff) begin
      nxt_pass_sum = '0;
      nxt_filt_ok  = 1'b0;
    end else if (chk_valid) begin
      if (chk_last) begin
        nxt_pass_sum = '0;
        nxt_filt_ok  = (acr_sum_step(pass_sum_ff, chk_data) == ref_sum_ff);
      end else begin
        nxt_pass_sum = acr_sum_step(pass_sum_ff, chk_data);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pass_sum_ff <= '0;
      filt_ok_ff  <= 1'b0;
    end else begin
      pass_sum_ff <= nxt_pass_sum;
      filt_ok_ff  <= nxt_filt_ok;
    end
  end

  always_comb begin
    status_word                        = '0;
    status_word[ST_PART_LO +: 2]       = PART_ID;
    status_word[ST_DIE_LO +: 3]        = die_ff;
    status_word[ST_LOW]                = power_ff[PW_LOW];
    status_word[ST_OVR]                = overrange;
    status_word[ST_DLOK]               = load_checksum_match_ff;
    status_word[ST_FOK]                = filt_ok_ff;
    status_word[ST_CUST]               = cust_ff;
    status_word[ST_BYP]                = ctrl1_ff[C1_BYP];
    status_word[ST_ONE]                = 1'b1;
    status_word[ST_RATE_LO +: 3]       = ctrl1_ff[C1_RATE_LO +: 3];
  end

  // select sticks until the next read; host keeps to one select per write
  always_comb begin
    nxt_sel = sel_ff;
    nxt_rv  = host_rd_stb;
    nxt_rd  = rd_ff;
    if (host_rd_stb) begin
      case (sel_ff)
        RD_STAT: nxt_rd = SW'(status_word);
        RD_THR:  nxt_rd = SW'(thresh_ff);
        RD_GAIN: nxt_rd = SW'(gain_ff);
        RD_OFF:  nxt_rd = SW'(offset_ff);
        default: nxt_rd = corr_data;
      endcase
      nxt_sel = RD_CONV;
    end
    if (c1_wr) begin
      if (host_wr_data[C1_RD_STAT]) begin
        nxt_sel = RD_STAT;
      end else if (host_wr_data[C1_RD_THR]) begin
        nxt_sel = RD_THR;
      end else if (host_wr_data[C1_RD_GAIN]) begin
        nxt_sel = RD_GAIN;
      end else if (host_wr_data[C1_RD_OFF]) begin
        nxt_sel = RD_OFF;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_ff <= RD_CONV;
      rv_ff  <= 1'b0;
      rd_ff  <= '0;
    end else begin
      sel_ff <= nxt_sel;
      rv_ff  <= nxt_rv;
      rd_ff  <= nxt_rd;
    end
  end

  acr_overload u_overload (
    .clk            (clk),
    .reset          (reset),
    .threshold      (thresh_ff),
    .dec1_valid     (dec1_valid),
    .dec1_data      (dec1_data),
    .mod_valid      (mod_valid),
    .mod_full_scale (mod_full_scale),
    .overrange      (overrange)
  );

  acr_correct u_correct (
    .clk       (clk),
    .reset     (reset),
    .gain      (gain_ff),
    .offset    (offset_ff),
    .in_valid  (conv_valid),
    .in_data   (conv_data),
    .out_valid (result_valid),
    .out_data  (corr_data)
  );

  assign result_data          = corr_data;
  assign rd_valid             = rv_ff;
  assign rd_data              = rd_ff;
  assign chip_sleep           = power_ff[PW_SLEEP];
  assign reduced_power_select = power_ff[PW_LOW];
  assign amp_sleep            = power_ff[PW_AMP];
  assign sync_pulse           = sync_ff;
  assign coeff_load_enable    = load_ff;
  assign coeff_wr_stb         = cw_stb_ff;
  assign coeff_wr_index       = cw_idx_ff;
  assign coeff_wr_data        = cw_data_ff;
  assign custom_coeffs_active = cust_ff;
  assign third_stage_bypass   = ctrl1_ff[C1_BYP];
  assign rate_divider_setting = ctrl1_ff[C1_RATE_LO +: 3];
  assign coeff_count          = ctrl1_ff[C1_LEN_LO +: 4];

endmodule // acr_regs

//--- design/acr_pkg.sv
package acr_pkg;

  localparam int DW = 16;
  localparam int AW = 16;
  localparam int SW = 24;
  localparam int IW = 6;

  localparam logic [AW-1:0] ADDR_CTRL1  = 16'h0001;
  localparam logic [AW-1:0] ADDR_POWER  = 16'h0002;
  localparam logic [AW-1:0] ADDR_OFFSET = 16'h0003;
  localparam logic [AW-1:0] ADDR_GAIN   = 16'h0004;
  localparam logic [AW-1:0] ADDR_THRESH = 16'h0005;

  localparam logic [DW-1:0] CTRL1_RST  = 16'h001A;
  localparam logic [DW-1:0] POWER_RST  = 16'h009B;
  localparam logic [DW-1:0] OFFSET_RST = 16'h0000;
  localparam logic [DW-1:0] GAIN_RST   = 16'hA000;
  localparam logic [DW-1:0] THRESH_RST = 16'hCCCC;

  // first control register fields
  localparam int C1_LOAD    = 15;
  localparam int C1_RD_THR  = 14;
  localparam int C1_RD_GAIN = 13;
  localparam int C1_RD_OFF  = 12;
  localparam int C1_RD_STAT = 11;
  localparam int C1_SYNC    = 9;
  localparam int C1_LEN_LO  = 5;
  localparam int C1_BYP     = 4;
  localparam int C1_RATE_LO = 0;
  localparam logic [DW-1:0] C1_SELF_CLR = 16'hFE00;

  // power control fields
  localparam int PW_SLEEP = 3;
  localparam int PW_LOW   = 2;
  localparam int PW_AMP   = 0;

  // status word fields
  localparam int ST_PART_LO = 14;
  localparam int ST_DIE_LO  = 11;
  localparam int ST_LOW     = 9;
  localparam int ST_OVR     = 8;
  localparam int ST_DLOK    = 7;
  localparam int ST_FOK     = 6;
  localparam int ST_CUST    = 5;
  localparam int ST_BYP     = 4;
  localparam int ST_ONE     = 3;
  localparam int ST_RATE_LO = 0;

  localparam logic [1:0]    PART_ID_DEF  = 2'h1;  // arbitrary value
  localparam int            UNITY_SHIFT  = 15;
  localparam logic [2:0]    FULL_RUN_MAX = 3'h4;
  localparam logic [IW-1:0] COEFF_GROUP  = 6'h03;

  typedef enum {RD_CONV, RD_STAT, RD_THR, RD_GAIN, RD_OFF} acr_rdsel_e;

  function automatic logic [DW-1:0] acr_sum_step(input logic [DW-1:0] sum,
                                                 input logic [DW-1:0] word);
    acr_sum_step = sum + word;
  endfunction

endpackage

//--- design/acr_overload.sv
module acr_overload
  import acr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic [DW-1:0] threshold,
  input  wire logic          dec1_valid,
  input  wire logic [SW-1:0] dec1_data,
  input  wire logic          mod_valid,
  input  wire logic          mod_full_scale,
  output logic               overrange
);

  logic [2:0]    run_ff;
  logic [2:0]    nxt_run;
  logic          ovr_ff;
  logic          nxt_ovr;
  logic [SW-1:0] mag;

  always_comb begin
    mag     = dec1_data[SW-1] ? SW'(-dec1_data) : dec1_data;
    nxt_run = run_ff;
    nxt_ovr = ovr_ff;
    if (dec1_valid) begin
      nxt_ovr = (mag[SW-2 -: DW] > threshold);
    end
    if (mod_valid) begin
      if (!mod_full_scale) begin
        nxt_run = 3'h0;
      end else if (run_ff == FULL_RUN_MAX) begin
        nxt_ovr = 1'b1;
      end else begin
        nxt_run = run_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_ff <= 3'h0;
      ovr_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      ovr_ff <= nxt_ovr;
    end
  end

  assign overrange = ovr_ff;

endmodule // acr_overload

//--- design/acr_correct.sv
module acr_correct
  import acr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic [DW-1:0] gain,
  input  wire logic [DW-1:0] offset,
  input  wire logic          in_valid,
  input  wire logic [SW-1:0] in_data,
  output logic               out_valid,
  output logic [SW-1:0]      out_data
);

  localparam logic signed [SW+1:0] MAX_OUT = 26'sh07FFFFF;
  localparam logic signed [SW+1:0] MIN_OUT = -26'sh0800000;

  logic                   stg_ff;
  logic                   nxt_stg;
  logic signed [SW+1:0]   scaled_ff;
  logic signed [SW+1:0]   nxt_scaled;
  logic                   val_ff;
  logic                   nxt_val;
  logic [SW-1:0]          out_ff;
  logic [SW-1:0]          nxt_out;
  logic signed [SW+DW:0]  prod;
  logic signed [SW+1:0]   sum;

  // gain first, offset after; one offset code is one output lsb
  always_comb begin
    prod       = $signed(in_data) * $signed({1'b0, gain});
    nxt_scaled = (SW+2)'(prod >>> UNITY_SHIFT);
    nxt_stg    = in_valid;
    sum        = scaled_ff + (SW+2)'($signed(offset));
    nxt_val    = stg_ff;
    nxt_out    = out_ff;
    if (stg_ff) begin
      if (sum > MAX_OUT) begin
        nxt_out = MAX_OUT[SW-1:0];
      end else if (sum < MIN_OUT) begin
        nxt_out = MIN_OUT[SW-1:0];
      end else begin
        nxt_out = sum[SW-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stg_ff    <= 1'b0;
      scaled_ff <= '0;
      val_ff    <= 1'b0;
      out_ff    <= '0;
    end else begin
      stg_ff    <= nxt_stg;
      scaled_ff <= nxt_scaled;
      val_ff    <= nxt_val;
      out_ff    <= nxt_out;
    end
  end

  assign out_valid = val_ff;
  assign out_data  = out_ff;

endmodule // acr_correct

//--- dv/acr_regs_checker.sv
module acr_regs_checker
  import acr_pkg::*;
#(
  parameter logic [1:0] PART_ID = PART_ID_DEF
) (
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          host_wr_stb,
  input wire logic [AW-1:0] host_wr_addr,
  input wire logic [DW-1:0] host_wr_data,
  input wire logic          host_rd_stb,
  input wire logic [SW-1:0] rd_data,
  input wire logic          coeff_load_enable,
  input wire logic          chip_sleep,
  input wire logic          reduced_power_select,
  input wire logic          amp_sleep,
  input wire logic          sync_pulse,
  input wire logic          third_stage_bypass,
  input wire logic [2:0]    rate_divider_setting,
  input wire logic          dec1_valid,
  input wire logic          mod_valid,
  input wire logic          mod_full_scale,
  input wire logic          overrange
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  logic pw;
  logic cw;
  // writes during a download are coefficients or the checksum word, not register updates
  assign pw = host_wr_stb && host_wr_addr == ADDR_POWER && !coeff_load_enable;
  assign cw = host_wr_stb && host_wr_addr == ADDR_CTRL1 && !coeff_load_enable;

  sequence s_st;
    cw && host_wr_data[C1_RD_STAT] ##1 !host_rd_stb && !host_wr_stb
      ##1 host_rd_stb && !host_wr_stb;
  endsequence

  a_sleep_write:
    assert property (pw |=> chip_sleep == $past(host_wr_data[PW_SLEEP]))
    else $error("chip sleep not taken from write");
  a_lowpwr_write:
    assert property (pw |=> reduced_power_select == $past(host_wr_data[PW_LOW]))
    else $error("low power select not taken from write");
  a_amp_write:
    assert property (pw |=> amp_sleep == $past(host_wr_data[PW_AMP]))
    else $error("amp sleep not taken from write");
  a_power_hold:
    assert property (!pw |=> $stable({chip_sleep, reduced_power_select, amp_sleep}))
    else $error("power levels moved without a write");
  a_part_fixed:
    assert property (s_st |=> rd_data[15:14] == PART_ID && !rd_data[10] && rd_data[ST_ONE])
    else $error("status fixed bits wrong");
  a_lowpwr_stat:
    assert property (s_st |=> rd_data[ST_LOW] == reduced_power_select)
    else $error("status low power bit wrong");
  a_bypass_stat:
    assert property (s_st |=> rd_data[ST_BYP] == third_stage_bypass)
    else $error("status bypass bit wrong");
  a_rate_stat:
    assert property (s_st |=> rd_data[2:0] == rate_divider_setting)
    else $error("status rate bits wrong");
  a_sync_start:
    assert property (cw && host_wr_data[C1_SYNC] |=> sync_pulse)
    else $error("sync pulse missing");
  a_sync_self_clear:
    assert property (sync_pulse |-> $past(cw && host_wr_data[C1_SYNC]))
    else $error("sync pulse without write");
  a_full_run:
    assert property ((mod_valid && mod_full_scale && !dec1_valid) [*5] |=> overrange)
    else $error("overrange not set after full scale run");

  c_stat: cover property (s_st);
  c_sync: cover property (sync_pulse);
  c_ovr:  cover property ($rose(overrange));
endmodule  // acr_regs_checker

bind acr_regs acr_regs_checker #(.PART_ID(PART_ID)) u_chk (
  .clk, .reset, .host_wr_stb, .host_wr_addr, .host_wr_data, .host_rd_stb, .rd_data,
  .coeff_load_enable, .chip_sleep, .reduced_power_select, .amp_sleep, .sync_pulse,
  .third_stage_bypass, .rate_divider_setting, .dec1_valid, .mod_valid, .mod_full_scale,
  .overrange
);

//--- dv/acr_host.sv
module acr_host
  import acr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rd_valid,
  input  wire logic [SW-1:0] rd_data,
  output logic               host_wr_stb,
  output logic [AW-1:0]      host_wr_addr,
  output logic [DW-1:0]      host_wr_data,
  output logic               host_rd_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_wr_stb  = 1'b0;
    host_rd_stb  = 1'b0;
    host_wr_addr = '0;
    host_wr_data = '0;
  end

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(negedge clk);
    host_wr_stb  = 1'b1;
    host_wr_addr = a;
    host_wr_data = (a == ADDR_POWER) ? (d | 16'h0002) : d;
    @(negedge clk);
    host_wr_stb  = 1'b0;
    // released lines flip so stale values never look valid
    host_wr_addr = ~host_wr_addr;
    host_wr_data = ~host_wr_data;
  endtask

  task automatic rd(output logic [SW-1:0] q, output bit ok);
    @(negedge clk);
    host_rd_stb = 1'b1;
    ok = 1'b0;
    q  = '0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      host_rd_stb = 1'b0;
      if (!ok && rd_valid === 1'b1) begin
        ok = 1'b1;
        q  = rd_data;
      end
    end
  endtask
endmodule  // acr_host

//--- dv/acr_regs_tb.sv
module acr_regs_tb
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk, reset, host_wr_stb, host_rd_stb, rd_valid, conv_valid, dec1_valid;
  logic          mod_valid, mod_full_scale, chk_valid, chk_last, chip_sleep, amp_sleep;
  logic          reduced_power_select, custom_coeffs_active, result_valid, overrange;
  logic          third_stage_bypass, coeff_load_enable, coeff_wr_stb;
  logic [2:0]    die, rate_divider_setting;
  logic [3:0]    coeff_count;
  logic [IW-1:0] coeff_wr_index;
  logic [AW-1:0] host_wr_addr;
  logic [DW-1:0] host_wr_data, chk_data, base, coeff_wr_data;
  logic [SW-1:0] rd_data, conv_data, dec1_data, result_data, q;
  int            n_fail, total_checks;
  bit            ok;

  acr_host host (.clk, .rd_valid, .rd_data, .host_wr_stb, .host_wr_addr, .host_wr_data,
                 .host_rd_stb);
  acr_regs dut (.clk, .reset, .host_wr_stb, .host_wr_addr, .host_wr_data, .host_rd_stb,
    .rd_valid, .rd_data, .die_pins(die), .conv_valid, .conv_data, .dec1_valid, .dec1_data,
    .mod_valid, .mod_full_scale, .chk_valid, .chk_data, .chk_last, .chip_sleep,
    .reduced_power_select, .amp_sleep, .sync_pulse(), .coeff_load_enable, .coeff_wr_stb,
    .coeff_wr_index, .coeff_wr_data, .custom_coeffs_active, .third_stage_bypass,
    .rate_divider_setting, .coeff_count, .result_valid, .result_data, .overrange);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [SW-1:0] e, input logic [SW-1:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rd_sel(input int b);
    host.wr(ADDR_CTRL1, base | (16'h0001 << b));
    host.rd(q, ok);
    if (!ok) begin
      chk("rd_valid", 1, 0);
      final_report();
    end
  endtask

  task automatic t_reset();
    chk("chip_sleep", 1, chip_sleep);
    chk("low_power", 0, reduced_power_select);
    chk("amp_sleep", 1, amp_sleep);
    rd_sel(C1_RD_GAIN);
    chk("gain", GAIN_RST, q);
    rd_sel(C1_RD_THR);
    chk("threshold", THRESH_RST, q);
    host.wr(16'h0007, 16'h1234);
    rd_sel(C1_RD_OFF);
    chk("offset", OFFSET_RST, q);
    rd_sel(C1_RD_STAT);
    chk("status", {PART_ID_DEF, 3'h5, 8'h03, 3'h2}, q);
  endtask

  task automatic t_power();
    for (int v = 0; v < 8; v++) begin
      host.wr(ADDR_POWER, {12'h000, v[2], v[1], 1'b0, v[0]});
      @(negedge clk);
      chk("chip_sleep", v[2], chip_sleep);
      chk("low_power", v[1], reduced_power_select);
      chk("amp_sleep", v[0], amp_sleep);
      rd_sel(C1_RD_STAT);
      chk("st_low", v[1], q[ST_LOW]);
    end
  endtask

  task automatic t_ctrl();
    for (int r = 0; r < 6; r++) begin
      base = {7'h00, 4'(r), r[0], 1'b1, r[2:0]};
      rd_sel(C1_RD_STAT);
      chk("st_bypass", r[0], q[ST_BYP]);
      chk("st_rate", r[2:0], q[2:0]);
      chk("ctrl_fields", {4'(r), r[0], r[2:0]},
          {coeff_count, third_stage_bypass, rate_divider_setting});
    end
    host.wr(ADDR_CTRL1, base | 16'h0200);
    base = CTRL1_RST;
  endtask

  task automatic t_corr(input logic [DW-1:0] g, o, input logic [SW-1:0] d, e);
    host.wr(ADDR_GAIN, g);
    host.wr(ADDR_OFFSET, o);
    @(negedge clk);
    conv_valid = 1'b1;
    conv_data  = d;
    @(negedge clk);
    conv_valid = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 5 && !ok; i++) begin
      if (result_valid === 1'b1) begin
        ok = 1'b1;
        chk("result", e, result_data);
      end
      @(negedge clk);
    end
    if (!ok) begin
      chk("result_valid", 1, 0);
      final_report();
    end
    host.rd(q, ok);
    chk("rd_conv", e, q);
  endtask

  task automatic dec(input logic [SW-1:0] d, input logic e);
    @(negedge clk);
    dec1_valid = 1'b1;
    dec1_data  = d;
    @(negedge clk);
    dec1_valid = 1'b0;
    @(negedge clk);
    chk("overrange", e, overrange);
  endtask

  task automatic mrun(input int n, input logic e);
    // one in-range sample first, so a run left over from before cannot count
    @(negedge clk);
    mod_valid      = 1'b1;
    mod_full_scale = 1'b0;
    @(negedge clk);
    mod_full_scale = 1'b1;
    repeat (n) @(negedge clk);
    mod_valid      = 1'b0;
    mod_full_scale = 1'b0;
    @(negedge clk);
    chk("ovr_run", e, overrange);
  endtask

  // checksum is the plain 16-bit sum of the three words below
  task automatic t_load(input logic [DW-1:0] s, input logic e);
    host.wr(ADDR_CTRL1, 16'h801A);
    for (int i = 0; i < 3; i++) begin
      host.wr(16'h0000, DW'(16'h1111 * (i + 1)));
      chk("coeff_wr", {2'h3, 6'(i), DW'(16'h1111 * (i + 1))},
          {coeff_load_enable, coeff_wr_stb, coeff_wr_index, coeff_wr_data});
    end
    host.wr(16'h0000, s);
    @(negedge clk);
    chk("custom", {1'b0, e}, {coeff_load_enable, custom_coeffs_active});
    rd_sel(C1_RD_STAT);
    chk("st_load_ok", e, q[ST_DLOK]);
    chk("st_custom", e, q[ST_CUST]);
  endtask

  task automatic t_flt(input logic [DW-1:0] w, input logic e);
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      chk_valid = 1'b1;
      chk_data  = (i == 2) ? w : DW'(16'h1111 * (i + 1));
      chk_last  = (i == 2);
    end
    @(negedge clk);
    chk_valid = 1'b0;
    chk_last  = 1'b0;
    rd_sel(C1_RD_STAT);
    chk("st_filter_ok", e, q[ST_FOK]);
  endtask

  initial begin
    reset = 1'b1;
    {conv_valid, dec1_valid, mod_valid, mod_full_scale, chk_valid, chk_last} = 6'h00;
    {conv_data, dec1_data, chk_data} = '0;
    die = 3'h5;
    base = CTRL1_RST;
    n_fail = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_power();
    t_ctrl();
    t_corr(16'h8000, 16'h0010, 24'h000100, 24'h000110);
    t_corr(16'h4000, 16'h0010, 24'h000100, 24'h000090);
    t_corr(16'h8000, 16'hFFF0, 24'h000100, 24'h0000F0);
    host.wr(ADDR_THRESH, 16'h0100);
    dec(24'h008080, 1'b1);
    dec(24'h008000, 1'b0);
    dec(24'hFF7F80, 1'b1);
    dec(24'h000000, 1'b0);
    mrun(4, 1'b0);
    mrun(5, 1'b1);
    die = 3'h2;
    rd_sel(C1_RD_STAT);
    chk("st_ovr", 1, q[ST_OVR]);
    chk("st_die", 3'h2, q[ST_DIE_LO +: 3]);
    t_load(16'h6666, 1'b1);
    t_load(16'h6667, 1'b0);
    t_load(16'h6666, 1'b1);
    t_flt(16'h3333, 1'b1);
    t_flt(16'h3334, 1'b0);
    final_report();
  end
endmodule  // acr_regs_tb
